// ### inc/gcbf_pkg.sv
// constants, types and helpers for the generator broadcast framer
package gcbf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BCAST_PERIOD_MS = 100;
  localparam longint unsigned BCAST_PERIOD_CYC_L = (64'(BCAST_PERIOD_MS) * 64'(CLK_HZ)) / 64'd1000;
  localparam int unsigned BCAST_PERIOD_CYC = int'(BCAST_PERIOD_CYC_L);

  ////////////////////////////////////////////////////////////////////////////
  // identifier layout
  localparam int ID_W = 29;
  localparam int SA_W = 8;
  localparam logic [2:0] BCAST_PRIORITY = 3'h3;
  localparam logic BCAST_EDP = 1'h0;
  localparam logic BCAST_DP = 1'h0;
  localparam logic [3:0] BCAST_DLC = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // frame catalogue, transmitted in index order
  localparam int FRAME_NUM = 7;
  localparam int FRAME_IDX_W = 3;
  localparam logic [2:0] FRM_GEN_CONTROL = 3'h0;
  localparam logic [2:0] FRM_GEN_AVERAGE = 3'h1;
  localparam logic [2:0] FRM_PHASE_A_BASIC = 3'h2;
  localparam logic [2:0] FRM_PHASE_A_POWER = 3'h3;
  localparam logic [2:0] FRM_PHASE_A_REACTIVE = 3'h4;
  localparam logic [2:0] FRM_PHASE_B_BASIC = 3'h5;
  localparam logic [2:0] FRM_PHASE_B_POWER = 3'h6;

  localparam logic [7:0] PF_GEN_CONTROL = 8'hFD;
  localparam logic [7:0] PS_GEN_CONTROL = 8'h93;
  localparam logic [7:0] PF_GEN_AVERAGE = 8'hFE;
  localparam logic [7:0] PS_GEN_AVERAGE = 8'h06;
  localparam logic [7:0] PF_PHASE_A_BASIC = 8'hFE;
  localparam logic [7:0] PS_PHASE_A_BASIC = 8'h03;
  localparam logic [7:0] PF_PHASE_A_POWER = 8'hFE;
  localparam logic [7:0] PS_PHASE_A_POWER = 8'h02;
  localparam logic [7:0] PF_PHASE_A_REACTIVE = 8'hFE;
  localparam logic [7:0] PS_PHASE_A_REACTIVE = 8'h01;
  localparam logic [7:0] PF_PHASE_B_BASIC = 8'hFE;
  localparam logic [7:0] PS_PHASE_B_BASIC = 8'h00;
  localparam logic [7:0] PF_PHASE_B_POWER = 8'hFD;
  localparam logic [7:0] PS_PHASE_B_POWER = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // field encodings
  localparam logic [1:0] READY_INACTIVE = 2'h0;
  localparam logic [1:0] READY_ACTIVE = 2'h1;
  localparam logic [1:0] READY_ERROR = 2'h2;
  localparam logic [1:0] READY_NA = 2'h3;
  localparam int READY_LSB = 3;
  localparam logic [7:0] NA_BYTE = 8'hFF;
  localparam logic [15:0] NA_WORD = 16'hFFFF;
  localparam logic [31:0] NA_DWORD = 32'hFFFFFFFF;
  localparam logic [63:0] NA_PAYLOAD = 64'hFFFFFFFFFFFFFFFF;
  // power fields carry value + 2e9; largest legal raw value below the indicator range
  localparam logic signed [33:0] PWR_OFFSET = 34'sh077359400;
  localparam logic signed [33:0] PWR_RAW_MAX = 34'sh0FAFFFFFF;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_OFFER} gcbf_state_e;

  // 16-bit field or not-available pattern
  function automatic logic [15:0] gcbf_field16(input logic [15:0] val, input logic avail);
    return avail ? val : NA_WORD;
  endfunction

  // 29-bit extended identifier: priority, edp, dp, pf, ps, source address
  function automatic logic [28:0] gcbf_make_id(input logic [7:0] pf, input logic [7:0] ps,
                                               input logic [7:0] sa);
    return {BCAST_PRIORITY, BCAST_EDP, BCAST_DP, pf, ps, sa};
  endfunction

endpackage

// ### logic/gcbf_tick.sv
// broadcast period timebase, one pulse per period
`timescale 1ns/10ps
module gcbf_tick #(
  parameter int unsigned PERIOD_CYC = gcbf_pkg::BCAST_PERIOD_CYC
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, low active
  input wire logic run, // count only while broadcasting is enabled
  output logic tick // one-cycle pulse at each period end
);
  import gcbf_pkg::*;

  initial
  begin
    if (PERIOD_CYC < 2)
      $error("gcbf_tick: PERIOD_CYC must be at least 2");
  end

  logic [31:0] cnt_ff;
  logic tick_ff;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || !run)
      cnt_ff <= 32'h0;
    else if (cnt_ff == 32'(PERIOD_CYC - 1))
      cnt_ff <= 32'h0;
    else
      cnt_ff <= cnt_ff + 32'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      tick_ff <= 1'b0;
    else
      tick_ff <= run && (cnt_ff == 32'(PERIOD_CYC - 1));
  end

  assign tick = tick_ff;

endmodule // gcbf_tick

// ### logic/gcbf_pwr_enc.sv
// signed power value to offset raw field, registered
`timescale 1ns/10ps
module gcbf_pwr_enc (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, low active
  input wire logic signed [31:0] value, // power, one unit per bit, signed
  input wire logic avail, // value is measured
  output logic [31:0] raw // field ready for the payload
);
  import gcbf_pkg::*;

  logic signed [33:0] sum;
  logic [31:0] raw_ff;

  assign sum = 34'(value) + PWR_OFFSET;

  // saturate rather than wrap so a huge reading never lands in the indicator range
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      raw_ff <= NA_DWORD;
    else if (!avail)
      raw_ff <= NA_DWORD;
    else if (sum < 34'sh0)
      raw_ff <= 32'h0;
    else if (sum > PWR_RAW_MAX)
      raw_ff <= PWR_RAW_MAX[31:0];
    else
      raw_ff <= sum[31:0];
  end

  assign raw = raw_ff;

endmodule // gcbf_pwr_enc

// ### logic/gcbf_framer.sv
// generator electrical broadcast framer: schedules and builds the seven periodic frames
`timescale 1ns/10ps
module gcbf_framer #(
  parameter int unsigned PERIOD_CYC = gcbf_pkg::BCAST_PERIOD_CYC // cycles per broadcast period
) (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic reset_n, // synchronous reset, low active
  input wire logic bcast_enable, // broadcasting enabled
  input wire logic [gcbf_pkg::SA_W-1:0] src_addr, // own source address
  // readiness
  input wire logic gen_not_ready, // set cannot auto-start and supply power
  input wire logic gen_ready_err, // readiness evaluation failed
  input wire logic gen_ready_avail, // readiness is known
  // averages, pre-scaled
  input wire logic [15:0] avg_vll, // line-line volts, 1 V/bit
  input wire logic [15:0] avg_vln, // line-neutral volts, 1 V/bit
  input wire logic [15:0] avg_freq, // frequency, 1/128 Hz/bit
  input wire logic [15:0] avg_curr, // current, 1 A/bit
  input wire logic [3:0] avg_avail, // per field: vll, vln, freq, curr
  // phase A
  input wire logic [15:0] pa_vll, // line-line volts, 1 V/bit
  input wire logic [15:0] pa_vln, // line-neutral volts, 1 V/bit
  input wire logic [15:0] pa_freq, // frequency, 1/128 Hz/bit
  input wire logic [15:0] pa_curr, // current, 1 A/bit
  input wire logic [3:0] pa_avail, // per field: vll, vln, freq, curr
  input wire logic signed [31:0] pa_real, // real power, W
  input wire logic signed [31:0] pa_appa, // apparent power
  input wire logic signed [31:0] pa_reac, // reactive power, var
  input wire logic [2:0] pa_pwr_avail, // per field: real, apparent, reactive
  // phase B
  input wire logic [15:0] pb_vll, // line-line volts, 1 V/bit
  input wire logic [15:0] pb_vln, // line-neutral volts, 1 V/bit
  input wire logic [15:0] pb_freq, // frequency, 1/128 Hz/bit
  input wire logic [15:0] pb_curr, // current, 1 A/bit
  input wire logic [3:0] pb_avail, // per field: vll, vln, freq, curr
  input wire logic signed [31:0] pb_real, // real power, W
  input wire logic signed [31:0] pb_appa, // apparent power
  input wire logic [1:0] pb_pwr_avail, // per field: real, apparent
  // toward the CAN controller
  output logic frame_valid, // frame offered
  input wire logic frame_ready, // controller accepts the frame
  output logic [gcbf_pkg::ID_W-1:0] frame_id, // 29-bit extended identifier
  output logic [3:0] frame_dlc, // data length
  output logic [63:0] frame_data, // payload, byte 1 in bits 7:0
  // status
  output logic busy, // a period's frames are still being sent
  output logic overrun // pulse: period ended with frames still unsent
);
  import gcbf_pkg::*;

  initial
  begin
    if (PERIOD_CYC < 64)
      $error("gcbf_framer: PERIOD_CYC too small to send all frames");
  end

  ////////////////////////////////////////////////////////////////////////////
  // timebase and power encoders

  logic tick;
  logic [31:0] pa_real_raw;
  logic [31:0] pa_appa_raw;
  logic [31:0] pa_reac_raw;
  logic [31:0] pb_real_raw;
  logic [31:0] pb_appa_raw;

  gcbf_tick #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_tick (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(bcast_enable),
    .tick(tick)
  );

  gcbf_pwr_enc u_pa_real (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .value(pa_real),
    .avail(pa_pwr_avail[0]),
    .raw(pa_real_raw)
  );

  gcbf_pwr_enc u_pa_appa (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .value(pa_appa),
    .avail(pa_pwr_avail[1]),
    .raw(pa_appa_raw)
  );

  gcbf_pwr_enc u_pa_reac (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .value(pa_reac),
    .avail(pa_pwr_avail[2]),
    .raw(pa_reac_raw)
  );

  gcbf_pwr_enc u_pb_real (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .value(pb_real),
    .avail(pb_pwr_avail[0]),
    .raw(pb_real_raw)
  );

  gcbf_pwr_enc u_pb_appa (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .value(pb_appa),
    .avail(pb_pwr_avail[1]),
    .raw(pb_appa_raw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // readiness code

  logic [1:0] ready_code;

  always_comb
  begin
    if (!gen_ready_avail)
      ready_code = READY_NA;
    else if (gen_ready_err)
      ready_code = READY_ERROR;
    else if (gen_not_ready)
      ready_code = READY_ACTIVE;
    else
      ready_code = READY_INACTIVE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending set: one bit per frame

  logic [FRAME_NUM-1:0] pending_ff;
  logic [FRAME_NUM-1:0] pend_set;
  logic [FRAME_NUM-1:0] pend_clr;
  gcbf_state_e state_ff;
  logic [FRAME_IDX_W-1:0] cur_idx_ff;
  logic [FRAME_IDX_W-1:0] first_idx;
  logic accept;

  assign accept = (state_ff == ST_OFFER) && frame_ready;
  assign pend_set = tick ? {FRAME_NUM{1'b1}} : '0;

  always_comb
  begin
    pend_clr = '0;
    if (accept)
      pend_clr[cur_idx_ff] = 1'b1;
  end

  // a new period arriving as a frame leaves re-arms that frame
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pending_ff <= '0;
    else
      pending_ff <= (pending_ff & ~pend_clr) | pend_set;
  end

  // lowest index first fixes the in-period order
  always_comb
  begin
    first_idx = '0;
    for (int i = FRAME_NUM - 1; i >= 0; i--)
    begin
      if (pending_ff[i])
        first_idx = FRAME_IDX_W'(i);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      overrun <= 1'b0;
    else
      overrun <= tick && ((pending_ff & ~pend_clr) != '0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_IDLE;
      cur_idx_ff <= '0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (pending_ff != '0)
          begin
            cur_idx_ff <= first_idx;
            state_ff <= ST_LOAD;
          end
        end
        ST_LOAD:
          state_ff <= ST_OFFER;
        ST_OFFER:
        begin
          if (frame_ready)
            state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame builder

  logic [7:0] nxt_pf;
  logic [7:0] nxt_ps;
  logic [63:0] nxt_data;

  always_comb
  begin
    nxt_pf = PF_GEN_CONTROL;
    nxt_ps = PS_GEN_CONTROL;
    nxt_data = NA_PAYLOAD;
    unique case (cur_idx_ff)
      FRM_GEN_CONTROL:
      begin
        nxt_pf = PF_GEN_CONTROL;
        nxt_ps = PS_GEN_CONTROL;
        nxt_data[READY_LSB +: 2] = ready_code;
      end
      FRM_GEN_AVERAGE:
      begin
        nxt_pf = PF_GEN_AVERAGE;
        nxt_ps = PS_GEN_AVERAGE;
        nxt_data[15:0] = gcbf_field16(avg_vll, avg_avail[0]);
        nxt_data[31:16] = gcbf_field16(avg_vln, avg_avail[1]);
        nxt_data[47:32] = gcbf_field16(avg_freq, avg_avail[2]);
        nxt_data[63:48] = gcbf_field16(avg_curr, avg_avail[3]);
      end
      FRM_PHASE_A_BASIC:
      begin
        nxt_pf = PF_PHASE_A_BASIC;
        nxt_ps = PS_PHASE_A_BASIC;
        nxt_data[15:0] = gcbf_field16(pa_vll, pa_avail[0]);
        nxt_data[31:16] = gcbf_field16(pa_vln, pa_avail[1]);
        nxt_data[47:32] = gcbf_field16(pa_freq, pa_avail[2]);
        nxt_data[63:48] = gcbf_field16(pa_curr, pa_avail[3]);
      end
      FRM_PHASE_A_POWER:
      begin
        nxt_pf = PF_PHASE_A_POWER;
        nxt_ps = PS_PHASE_A_POWER;
        nxt_data[31:0] = pa_real_raw;
        nxt_data[63:32] = pa_appa_raw;
      end
      FRM_PHASE_A_REACTIVE:
      begin
        nxt_pf = PF_PHASE_A_REACTIVE;
        nxt_ps = PS_PHASE_A_REACTIVE;
        nxt_data[31:0] = pa_reac_raw;
      end
      FRM_PHASE_B_BASIC:
      begin
        nxt_pf = PF_PHASE_B_BASIC;
        nxt_ps = PS_PHASE_B_BASIC;
        nxt_data[15:0] = gcbf_field16(pb_vll, pb_avail[0]);
        nxt_data[31:16] = gcbf_field16(pb_vln, pb_avail[1]);
        nxt_data[47:32] = gcbf_field16(pb_freq, pb_avail[2]);
        nxt_data[63:48] = gcbf_field16(pb_curr, pb_avail[3]);
      end
      FRM_PHASE_B_POWER:
      begin
        nxt_pf = PF_PHASE_B_POWER;
        nxt_ps = PS_PHASE_B_POWER;
        nxt_data[31:0] = pb_real_raw;
        nxt_data[63:32] = pb_appa_raw;
      end
      default:
      begin
        nxt_pf = PF_GEN_CONTROL;
        nxt_ps = PS_GEN_CONTROL;
        nxt_data = NA_PAYLOAD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers: snapshot taken in LOAD, held while offered

  logic [ID_W-1:0] id_ff;
  logic [63:0] data_ff;
  logic [3:0] dlc_ff;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      id_ff <= '0;
      data_ff <= NA_PAYLOAD;
      dlc_ff <= 4'h0;
    end
    else if (state_ff == ST_LOAD)
    begin
      id_ff <= gcbf_make_id(nxt_pf, nxt_ps, src_addr);
      data_ff <= nxt_data;
      dlc_ff <= BCAST_DLC;
    end
  end

  assign frame_valid = (state_ff == ST_OFFER);
  assign frame_id = id_ff;
  assign frame_dlc = dlc_ff;
  assign frame_data = data_ff;
  assign busy = (pending_ff != '0) || (state_ff != ST_IDLE);

endmodule // gcbf_framer

// ### test/gcbf_framer_monitor.sv
// concurrent checks on the broadcast framer's frame offer and period timing
`timescale 1ns/10ps
module gcbf_framer_monitor #(
  parameter int unsigned PERIOD_CYC = 200 // cycles per broadcast period
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, low active
  input wire logic bcast_enable, // broadcasting enabled
  input wire logic frame_valid, // frame offered
  input wire logic frame_ready, // controller accepts
  input wire logic [28:0] frame_id, // extended identifier
  input wire logic [3:0] frame_dlc, // data length
  input wire logic [63:0] frame_data, // payload
  input wire logic busy, // frames pending
  input wire logic overrun // late period pulse
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last period start; only trusted while no overrun or pause intervened
  logic [15:0] gap_ff;
  logic steady_ff;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      gap_ff <= 16'h0000;
    else if ($rose(busy))
      gap_ff <= 16'h0001;
    else if (gap_ff != 16'hFFFF)
      gap_ff <= gap_ff + 16'h0001;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || !bcast_enable || overrun)
      steady_ff <= 1'b0;
    else if ($rose(busy))
      steady_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_offer_hold: assert property (frame_valid && !frame_ready |=>
    frame_valid && $stable(frame_id) && $stable(frame_data) && $stable(frame_dlc))
    else $error("offered frame changed before it was taken");
  chk_dlc_eight: assert property (frame_valid |-> frame_dlc == 4'h8)
    else $error("frame length is not eight bytes");
  chk_fixed_prio: assert property (frame_valid |-> frame_id[28:24] == 5'h0C)
    else $error("priority or page bits wrong");
  chk_known_group: assert property (frame_valid |-> frame_id[23:8] inside
    {16'hFD93, 16'hFE06, 16'hFE03, 16'hFE02, 16'hFE01, 16'hFE00, 16'hFDFF})
    else $error("unknown format and specific pair");
  chk_ctrl_ones: assert property (frame_valid && frame_id[23:8] == 16'hFD93 |->
    frame_data[63:5] == {59{1'b1}} && frame_data[2:0] == 3'h7)
    else $error("unused control bits not all ones");
  chk_ctrl_then_avg: assert property (frame_valid && frame_ready && frame_id[23:8] == 16'hFD93
    && steady_ff && gap_ff < 16'(PERIOD_CYC - 8) |-> ##3 frame_valid && frame_id[23:8] == 16'hFE06)
    else $error("average frame did not follow control frame");
  chk_start_ctrl: assert property ($rose(busy) |-> ##2 frame_valid && frame_id[23:8] == 16'hFD93)
    else $error("period did not open with control frame");
  chk_idle_quiet: assert property (!busy |-> !frame_valid)
    else $error("frame offered while idle");
  chk_overrun_cause: assert property (overrun |-> $past(busy) ##1 !overrun)
    else $error("overrun without pending frames or too long");
  chk_period_exact: assert property ($rose(busy) && steady_ff |-> gap_ff == 16'(PERIOD_CYC))
    else $error("broadcast period length wrong");
endmodule // gcbf_framer_monitor

bind gcbf_framer gcbf_framer_monitor #(.PERIOD_CYC(PERIOD_CYC)) u_mon (.clk_sys(clk_sys), .reset_n(reset_n),
  .bcast_enable(bcast_enable), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_id(frame_id),
  .frame_dlc(frame_dlc), .frame_data(frame_data), .busy(busy), .overrun(overrun));

// ### test/gcbf_can_model.sv
// receiving CAN controller model: takes offered frames after a set stall
`timescale 1ns/10ps
module gcbf_can_model (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, low active
  input wire logic [7:0] wait_cyc, // stall cycles before each accept
  input wire logic frame_valid, // frame offered
  input wire logic [28:0] frame_id, // extended identifier
  input wire logic [3:0] frame_dlc, // data length
  input wire logic [63:0] frame_data, // payload
  output logic frame_ready // accept
);
  logic [7:0] stall_ff;
  logic [96:0] rx[$]; // id, then dlc, then payload
  // zero stall leaves ready up before any offer, as an idle controller may
  assign frame_ready = (stall_ff >= wait_cyc);
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || (frame_valid && frame_ready))
      stall_ff <= 8'h00;
    else if (frame_valid)
      stall_ff <= stall_ff + 8'h01;
  end
  // plain always: the bench also empties the queue, which an always_ff may not share
  always @(posedge clk_sys)
  begin
    if (reset_n && frame_valid && frame_ready)
      rx.push_back({frame_id, frame_dlc, frame_data});
  end
endmodule // gcbf_can_model

// ### test/testbench.sv
// self-checking bench for the generator broadcast framer
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module testbench;
  import gcbf_pkg::*;
  localparam int unsigned PER = 200;
  localparam logic [15:0] PFPS[7] = '{16'hFD93, 16'hFE06, 16'hFE03, 16'hFE02, 16'hFE01, 16'hFE00, 16'hFDFF};
  typedef struct {logic nr, er, av; logic [1:0] code; logic [3:0] m; logic signed [31:0] p; logic [7:0] sa, st;} gcbf_row_s;
  // readiness inputs, expected code, availability, power, address, stall
  gcbf_row_s rows[4] = '{
    '{1'b0, 1'b0, 1'b1, 2'h0, 4'hF, 32'sd1000, 8'h2C, 8'h00},
    '{1'b1, 1'b0, 1'b1, 2'h1, 4'h0, -32'sd2000000000, 8'h00, 8'h03},
    '{1'b1, 1'b1, 1'b1, 2'h2, 4'h5, 32'sh80000000, 8'hFF, 8'h00},
    '{1'b0, 1'b1, 1'b0, 2'h3, 4'hA, 32'sh7FFFFFFF, 8'hA7, 8'h02}};
  logic clk_sys = 1'b0, reset_n = 1'b0, bcast_enable = 1'b1;
  logic gen_not_ready = 1'b0, gen_ready_err = 1'b0, gen_ready_avail = 1'b1;
  logic [7:0] src_addr = 8'h00, wait_cyc = 8'h00;
  logic [15:0] fb = 16'h1234;
  logic [3:0] vmask = 4'hF;
  logic signed [31:0] pwr = 32'sh0;
  logic frame_valid, frame_ready, busy, overrun;
  logic [28:0] frame_id;
  logic [3:0] frame_dlc;
  logic [63:0] frame_data;
  int n_mismatch = 0, checks = 0;

  function automatic logic [15:0] fv(logic [15:0] b, int i);
    return b + 16'h0101 * 16'(i);
  endfunction
  function automatic logic [63:0] quad(int g);
    return {vmask[3] ? fv(fb, g * 4 + 3) : 16'hFFFF, vmask[2] ? fv(fb, g * 4 + 2) : 16'hFFFF,
            vmask[1] ? fv(fb, g * 4 + 1) : 16'hFFFF, vmask[0] ? fv(fb, g * 4) : 16'hFFFF};
  endfunction
  // offset field, floored at zero; absent values read all ones
  function automatic logic [31:0] pe(logic signed [31:0] v, logic a);
    longint r;
    r = longint'(v) + 64'sd2000000000;
    return !a ? 32'hFFFFFFFF : (r < 0) ? 32'h0 : r[31:0];
  endfunction
  function automatic logic [63:0] expd(int f, logic [1:0] code);
    case (f)
      0: return ~64'h18 | (64'(code) << 3);
      1: return quad(0);
      2: return quad(1);
      3: return {pe(~pwr, vmask[1]), pe(pwr, vmask[0])};
      4: return {32'hFFFFFFFF, pe(pwr >>> 1, vmask[2])};
      5: return quad(2);
      default: return {pe(~(pwr >>> 2), vmask[1]), pe(pwr >>> 2, vmask[0])};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  gcbf_framer #(.PERIOD_CYC(PER)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .bcast_enable(bcast_enable),
    .src_addr(src_addr), .gen_not_ready(gen_not_ready), .gen_ready_err(gen_ready_err),
    .gen_ready_avail(gen_ready_avail), .avg_vll(fv(fb, 0)), .avg_vln(fv(fb, 1)), .avg_freq(fv(fb, 2)),
    .avg_curr(fv(fb, 3)), .avg_avail(vmask), .pa_vll(fv(fb, 4)), .pa_vln(fv(fb, 5)), .pa_freq(fv(fb, 6)),
    .pa_curr(fv(fb, 7)), .pa_avail(vmask), .pa_real(pwr), .pa_appa(~pwr), .pa_reac(pwr >>> 1),
    .pa_pwr_avail(vmask[2:0]), .pb_vll(fv(fb, 8)), .pb_vln(fv(fb, 9)), .pb_freq(fv(fb, 10)),
    .pb_curr(fv(fb, 11)), .pb_avail(vmask), .pb_real(pwr >>> 2), .pb_appa(~(pwr >>> 2)),
    .pb_pwr_avail(vmask[1:0]), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_id(frame_id),
    .frame_dlc(frame_dlc), .frame_data(frame_data), .busy(busy), .overrun(overrun));
  gcbf_can_model can (.clk_sys(clk_sys), .reset_n(reset_n), .wait_cyc(wait_cyc), .frame_valid(frame_valid),
    .frame_id(frame_id), .frame_dlc(frame_dlc), .frame_data(frame_data), .frame_ready(frame_ready));

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apply(gcbf_row_s r);
    @(posedge clk_sys);
    gen_not_ready <= r.nr;
    gen_ready_err <= r.er;
    gen_ready_avail <= r.av;
    vmask <= r.m;
    pwr <= r.p;
    src_addr <= r.sa;
    wait_cyc <= r.st;
    fb <= {r.sa, ~r.sa};
  endtask
  // bounded wait, so a stuck design shows as a mismatch and not a hang
  task automatic wait_sig(ref logic s, input logic v);
    int k;
    k = 0;
    // step off the launching edge before the first look
    @(negedge clk_sys);
    while (s !== v && k < 4 * PER)
    begin
      @(negedge clk_sys);
      k++;
    end
    `CHK(s, v)
  endtask
  task automatic take(int n);
    int k;
    k = 0;
    while (can.rx.size() < n && k < 4 * PER)
    begin
      @(negedge clk_sys);
      k++;
    end
    `CHK(can.rx.size() >= n, 1'b1)
  endtask
  task automatic chk_idle();
    `CHK(frame_valid, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(overrun, 1'b0)
    `CHK(frame_dlc, 4'h0)
    `CHK(frame_id, 29'h0)
    `CHK(frame_data, {64{1'b1}})
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk_idle();
    foreach (rows[i])
    begin
      apply(rows[i]);
      take(7);
      for (int f = 0; f < 7; f++)
        `CHK(can.rx[f], {5'h0C, PFPS[f], src_addr, 4'h8, expd(f, rows[i].code)})
      can.rx.delete();
    end
    // controller too slow for the period: late period flagged
    @(posedge clk_sys);
    wait_cyc <= 8'd40;
    wait_sig(overrun, 1'b1);
    @(posedge clk_sys);
    wait_cyc <= 8'h00;
    wait_sig(busy, 1'b0);
    // paused broadcasting sends nothing, then resumes with the control frame
    @(posedge clk_sys);
    bcast_enable <= 1'b0;
    repeat (PER) @(negedge clk_sys);
    can.rx.delete();
    repeat (2 * PER) @(negedge clk_sys);
    `CHK(can.rx.size(), 0)
    @(posedge clk_sys);
    bcast_enable <= 1'b1;
    take(1);
    `CHK(can.rx[0][91:76], 16'hFD93)
    // reset in the middle of a period, just after a frame is taken
    wait_sig(frame_valid, 1'b1);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_idle();
    can.rx.delete();
    @(posedge clk_sys);
    reset_n <= 1'b1;
    take(7);
    `CHK(can.rx[6][91:76], 16'hFDFF)
    results();
  end
  initial
  begin
    repeat (40 * PER) @(posedge clk_sys);
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    results();
  end
endmodule // testbench
